// File: rtl/hlsu_core.sv
// module: halfword load/store unit with add halfword and apb registers
`default_nettype none
module hlsu_core
   import hlsu_pkg::*;
(
   input  wire logic             i_clk_sys,
   input  wire logic             i_nrst,
   input  wire logic             i_ce,
   input  wire logic             i_instr_valid,
   input  wire hlsu_instr_type   i_instr,
   input  wire logic [15:0]      i_instr_addr,
   output logic                  o_instr_ready,
   output hlsu_mem_req_type      o_mem_req,
   input  wire logic             i_mem_ack,
   input  wire logic [15:0]      i_mem_rdata,
   output hlsu_wb_type           o_wb,
   output logic                  o_busy,
   output logic [31:0]           o_psw,
   input  wire logic             i_psel,
   input  wire logic             i_penable,
   input  wire logic             i_pwrite,
   input  wire logic [11:0]      i_paddr,
   input  wire logic [31:0]      i_pwdata,
   output logic [31:0]           o_prdata,
   output logic                  o_pready,
   output logic                  o_pslverr
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   logic [15:0]      gpr_reg [16];
   hlsu_state_type   state_reg;
   hlsu_kind_type    kind_reg;
   logic [3:0]       tgt_reg;
   hlsu_mem_req_type mem_reg;
   hlsu_wb_type      wb_reg;
   logic [31:0]      psw_reg;
   logic             en_reg;
   logic             illegal_reg;
   logic [31:0]      prdata_reg;

   hlsu_wb_type      wb_next;
   hlsu_mem_req_type mem_issue;
   hlsu_kind_type    kind_next;
   logic [3:0]       cc_next;
   logic             cc_we;
   logic             go_mem;
   logic             illegal_evt;
   logic             take;
   logic             fin;
   logic [15:0]      ea;
   logic [15:0]      r1_val;
   logic [15:0]      x2_val;
   logic [15:0]      ahi_ref;
   logic             apb_wr;
   logic             apb_sw_ok;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // greater/less from a loaded value; carry and overflow left cleared
   function automatic logic [3:0] gl_cc(input logic [15:0] v);
      return {2'b00, ~v[15] & (|v), v[15]};
   endfunction : gl_cc

   // returns {c, v, g, l, sum}
   function automatic logic [19:0] add_cc(input logic [15:0] a, input logic [15:0] b);
      logic [16:0] s;
      s = {1'b0, a} + {1'b0, b};
      return {s[16], (a[15] == b[15]) && (s[15] != a[15]),
              ~s[15] & (|s[15:0]), s[15], s[15:0]};
   endfunction : add_cc

   function automatic logic apb_hit(input logic [11:0] a);
      return (a == ADDR_CTRL) || (a == ADDR_STATUS) || (a == ADDR_PSW)
             || ((a & GPR_MASK) == ADDR_GPR_BASE);
   endfunction : apb_hit

   function automatic logic [31:0] apb_read(input logic [11:0] a);
      logic [31:0] v;
      v = 32'h0000_0000;
      if (a == ADDR_CTRL) begin
         v[CTRL_EN_BIT] = en_reg;
      end else if (a == ADDR_STATUS) begin
         v[STAT_ILL_BIT]  = illegal_reg;
         v[STAT_BUSY_BIT] = (state_reg == ST_MEM);
      end else if (a == ADDR_PSW) begin
         v = psw_reg;
      end else if ((a & GPR_MASK) == ADDR_GPR_BASE) begin
         v[15:0] = gpr_reg[a[5:2]];
      end
      return v;
   endfunction : apb_read

   // ---------------------------------------------------------------
   // decode and execute
   // ---------------------------------------------------------------
   assign o_instr_ready = (state_reg == ST_IDLE) && en_reg;
   assign take          = i_ce && i_instr_valid && o_instr_ready;
   assign fin           = i_ce && (state_reg == ST_MEM) && i_mem_ack;
   assign r1_val        = gpr_reg[i_instr.r1];
   assign x2_val        = gpr_reg[i_instr.x2];
   assign ea            = i_instr.addr_field + x2_val;
   assign ahi_ref       = r1_val + ea;

   always_comb begin
      wb_next     = '0;
      mem_issue   = '0;
      kind_next   = K_LH;
      cc_next     = psw_reg[PSW_CC_C:PSW_CC_L];
      cc_we       = 1'b0;
      go_mem      = 1'b0;
      illegal_evt = 1'b0;
      if (take) begin
         mem_issue.valid = 1'b1;
         mem_issue.addr  = ea;
         unique case (i_instr.opcode)
            OP_LOAD_HALFWORD_REGREG: begin
               wb_next = {1'b1, i_instr.r1, x2_val};
               cc_next = gl_cc(x2_val);
               cc_we   = 1'b1;
            end
            OP_LOAD_HALFWORD_IMMEDIATE: begin
               wb_next = {1'b1, i_instr.r1, ea};
               cc_next = gl_cc(ea);
               cc_we   = 1'b1;
            end
            OP_LOAD_BYTE_REGREG: begin
               wb_next = {1'b1, i_instr.r1, 8'h00, x2_val[7:0]};
            end
            OP_STORE_BYTE_REGREG: begin
               wb_next = {1'b1, i_instr.x2, x2_val[15:8], r1_val[7:0]};
            end
            OP_ADD_HALFWORD_REGREG: begin
               {cc_next, wb_next.data} = add_cc(r1_val, x2_val);
               wb_next.valid = 1'b1;
               wb_next.index = i_instr.r1;
               cc_we         = 1'b1;
            end
            OP_ADD_HALFWORD_IMMEDIATE: begin
               {cc_next, wb_next.data} = add_cc(r1_val, ea);
               wb_next.valid = 1'b1;
               wb_next.index = i_instr.r1;
               cc_we         = 1'b1;
            end
            OP_LOAD_HALFWORD_MEMORY: begin
               go_mem    = 1'b1;
               kind_next = K_LH;
            end
            OP_ADD_HALFWORD_MEMORY: begin
               go_mem    = 1'b1;
               kind_next = K_AH;
            end
            OP_LOAD_BYTE_MEMORY: begin
               go_mem             = 1'b1;
               kind_next          = K_LB;
               mem_issue.byte_sel = 1'b1;
            end
            OP_LOAD_MULTIPLE: begin
               go_mem    = 1'b1;
               kind_next = K_LM;
            end
            OP_STORE_HALFWORD_MEMORY: begin
               go_mem          = 1'b1;
               kind_next       = K_STH;
               mem_issue.write = 1'b1;
               mem_issue.wdata = r1_val;
            end
            OP_STORE_BYTE_MEMORY: begin
               go_mem             = 1'b1;
               kind_next          = K_STB;
               mem_issue.write    = 1'b1;
               mem_issue.byte_sel = 1'b1;
               mem_issue.wdata    = {8'h00, r1_val[7:0]};
            end
            default: begin
               illegal_evt = 1'b1;
            end
         endcase
      end else if (fin) begin
         unique case (kind_reg)
            K_LH: begin
               wb_next = {1'b1, tgt_reg, i_mem_rdata};
               cc_next = gl_cc(i_mem_rdata);
               cc_we   = 1'b1;
            end
            K_LB: begin
               wb_next = {1'b1, tgt_reg, 8'h00, i_mem_rdata[7:0]};
            end
            K_LM: begin
               wb_next = {1'b1, tgt_reg, i_mem_rdata};
            end
            K_AH: begin
               {cc_next, wb_next.data} = add_cc(gpr_reg[tgt_reg], i_mem_rdata);
               wb_next.valid = 1'b1;
               wb_next.index = tgt_reg;
               cc_we         = 1'b1;
            end
            K_STH, K_STB: begin
               wb_next = '0;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // sequencer and memory request
   // ---------------------------------------------------------------
   // the request is held unchanged until the acknowledge edge
   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         state_reg <= ST_IDLE;
         kind_reg  <= K_LH;
         tgt_reg   <= 4'h0;
         mem_reg   <= '0;
      end else if (i_ce) begin
         if (take && go_mem) begin
            state_reg <= ST_MEM;
            kind_reg  <= kind_next;
            tgt_reg   <= i_instr.r1;
            mem_reg   <= mem_issue;
         end else if (fin) begin
            if (kind_reg == K_LM && tgt_reg != LAST_REGISTER) begin
               tgt_reg      <= tgt_reg + 4'h1;
               mem_reg.addr <= mem_reg.addr + HALFWORD_STEP;
            end else begin
               state_reg     <= ST_IDLE;
               mem_reg.valid <= 1'b0;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // general registers
   // ---------------------------------------------------------------
   // software writes lose to execution and are dropped while busy
   assign apb_wr    = i_ce && i_psel && i_penable && i_pwrite;
   assign apb_sw_ok = apb_wr && (state_reg == ST_IDLE) && !take;

   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         for (int i = 0; i < 16; i++) begin
            gpr_reg[i] <= 16'h0000;
         end
      end else if (i_ce) begin
         if (wb_next.valid) begin
            gpr_reg[wb_next.index] <= wb_next.data;
         end else if (apb_sw_ok && (i_paddr & GPR_MASK) == ADDR_GPR_BASE) begin
            gpr_reg[i_paddr[5:2]] <= i_pwdata[15:0];
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         wb_reg <= '0;
      end else if (i_ce) begin
         wb_reg <= wb_next;
      end
   end

   // ---------------------------------------------------------------
   // program status word
   // ---------------------------------------------------------------
   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         psw_reg <= PSW_RESET;
      end else if (i_ce) begin
         if (apb_sw_ok && i_paddr == ADDR_PSW) begin
            psw_reg <= i_pwdata;
         end
         if (take) begin
            psw_reg[PSW_IA_MSB:0] <= i_instr_addr;
         end
         if (cc_we) begin
            psw_reg[PSW_CC_C:PSW_CC_L] <= cc_next;
         end
      end
   end

   // ---------------------------------------------------------------
   // apb slave
   // ---------------------------------------------------------------
   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         en_reg      <= CTRL_EN_RESET;
         illegal_reg <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
      end else if (i_ce) begin
         if (apb_wr && i_paddr == ADDR_CTRL) begin
            en_reg <= i_pwdata[CTRL_EN_BIT];
         end
         // a new illegal opcode wins over a write-one clear
         if (illegal_evt) begin
            illegal_reg <= 1'b1;
         end else if (apb_wr && i_paddr == ADDR_STATUS && i_pwdata[STAT_ILL_BIT]) begin
            illegal_reg <= 1'b0;
         end
         if (i_psel && !i_penable) begin
            prdata_reg <= apb_read(i_paddr);
         end
      end
   end

   assign o_pready  = i_ce;
   assign o_pslverr = i_psel && i_penable && !apb_hit(i_paddr);
   assign o_prdata  = prdata_reg;
   assign o_mem_req = mem_reg;
   assign o_wb      = wb_reg;
   assign o_busy    = (state_reg == ST_MEM);
   assign o_psw     = psw_reg;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb_sys @(posedge i_clk_sys); endclocking
   default disable iff (!i_nrst);

   property p_lhi_value;
      take && i_instr.opcode == OP_LOAD_HALFWORD_IMMEDIATE |=>
         o_wb.valid && o_wb.index == $past(i_instr.r1) && o_wb.data == $past(ea);
   endproperty
   a_lhi_value: assert property (p_lhi_value) else $error("immediate load value wrong");

   property p_ahi_value;
      take && i_instr.opcode == OP_ADD_HALFWORD_IMMEDIATE |=>
         o_wb.valid && o_wb.data == $past(ahi_ref);
   endproperty
   a_ahi_value: assert property (p_ahi_value) else $error("immediate add value wrong");

   property p_load_gl;
      take && i_instr.opcode == OP_LOAD_HALFWORD_REGREG |=>
         o_psw[PSW_CC_L] == $past(x2_val[15])
         && o_psw[PSW_CC_G] == (!$past(x2_val[15]) && $past(x2_val) != 16'h0000);
   endproperty
   a_load_gl: assert property (p_load_gl) else $error("load greater/less bits wrong");

   property p_sth_req;
      take && i_instr.opcode == OP_STORE_HALFWORD_MEMORY |=>
         o_mem_req.valid && o_mem_req.write && !o_mem_req.byte_sel
         && o_mem_req.addr == $past(ea) && o_mem_req.wdata == $past(r1_val);
   endproperty
   a_sth_req: assert property (p_sth_req) else $error("store halfword request wrong");

   property p_store_cc;
      fin && (kind_reg == K_STH || kind_reg == K_STB) |=>
         $stable(o_psw[PSW_CC_C:PSW_CC_L]) && !o_wb.valid && !o_busy;
   endproperty
   a_store_cc: assert property (p_store_cc) else $error("store changed state");

   property p_lb_zero;
      fin && kind_reg == K_LB |=>
         o_wb.valid && o_wb.data == {8'h00, $past(i_mem_rdata[7:0])};
   endproperty
   a_lb_zero: assert property (p_lb_zero) else $error("load byte high byte not zero");

   property p_store_byte_regreg_keep;
      take && i_instr.opcode == OP_STORE_BYTE_REGREG |=>
         o_wb.index == $past(i_instr.x2)
         && o_wb.data == {$past(x2_val[15:8]), $past(r1_val[7:0])};
   endproperty
   a_store_byte_regreg_keep: assert property (p_store_byte_regreg_keep) else $error("store byte register wrong");

   property p_lm_step;
      fin && kind_reg == K_LM && tgt_reg != LAST_REGISTER |=>
         o_mem_req.valid && o_mem_req.addr == 16'($past(o_mem_req.addr) + HALFWORD_STEP);
   endproperty
   a_lm_step: assert property (p_lm_step) else $error("load multiple step wrong");

   property p_lm_end;
      fin && kind_reg == K_LM && tgt_reg == LAST_REGISTER |=>
         !o_busy && !o_mem_req.valid && o_wb.index == LAST_REGISTER;
   endproperty
   a_lm_end: assert property (p_lm_end) else $error("load multiple did not stop");

   property p_req_hold;
      o_mem_req.valid && !(i_ce && i_mem_ack) |=> $stable(o_mem_req);
   endproperty
   a_req_hold: assert property (p_req_hold) else $error("memory request changed early");

   c_lm_full:  cover property (fin && kind_reg == K_LM && tgt_reg == LAST_REGISTER);
   c_ahi:      cover property (take && i_instr.opcode == OP_ADD_HALFWORD_IMMEDIATE);
   c_stb:      cover property (fin && kind_reg == K_STB);
   c_illegal:  cover property (illegal_evt);

endmodule : hlsu_core
`default_nettype wire

// File: rtl/hlsu_pkg.sv
// package: constants and types shared by the halfword load/store unit
`default_nettype none
package hlsu_pkg;
   // ---------------------------------------------------------------
   // operation codes
   // ---------------------------------------------------------------
   localparam logic [7:0]  OP_LOAD_HALFWORD_REGREG    = 8'h08;
   localparam logic [7:0]  OP_LOAD_HALFWORD_MEMORY    = 8'h48;
   localparam logic [7:0]  OP_LOAD_HALFWORD_IMMEDIATE = 8'hC8;
   localparam logic [7:0]  OP_STORE_HALFWORD_MEMORY   = 8'h40;
   localparam logic [7:0]  OP_LOAD_BYTE_REGREG        = 8'h93;
   localparam logic [7:0]  OP_LOAD_BYTE_MEMORY        = 8'hD3;
   localparam logic [7:0]  OP_STORE_BYTE_REGREG       = 8'h92;
   localparam logic [7:0]  OP_STORE_BYTE_MEMORY       = 8'hD2;
   localparam logic [7:0]  OP_LOAD_MULTIPLE           = 8'hD1;
   localparam logic [7:0]  OP_ADD_HALFWORD_REGREG     = 8'h0A;
   localparam logic [7:0]  OP_ADD_HALFWORD_MEMORY     = 8'h4A;
   localparam logic [7:0]  OP_ADD_HALFWORD_IMMEDIATE  = 8'hCA;
   // ---------------------------------------------------------------
   // program status word layout (bit n of the word is psw[31-n])
   // ---------------------------------------------------------------
   localparam int          PSW_CC_C      = 19;
   localparam int          PSW_CC_V      = 18;
   localparam int          PSW_CC_G      = 17;
   localparam int          PSW_CC_L      = 16;
   localparam int          PSW_IA_MSB    = 15;
   localparam logic [31:0] PSW_RESET     = 32'h0000_0000;
   localparam logic [3:0]  LAST_REGISTER = 4'hF;
   localparam logic [15:0] HALFWORD_STEP = 16'h0002;
   // ---------------------------------------------------------------
   // apb register map
   // ---------------------------------------------------------------
   localparam logic [11:0] ADDR_CTRL     = 12'h000;
   localparam logic [11:0] ADDR_STATUS   = 12'h004;
   localparam logic [11:0] ADDR_PSW      = 12'h008;
   localparam logic [11:0] ADDR_GPR_BASE = 12'h040;
   localparam logic [11:0] GPR_MASK      = 12'hFC0;
   localparam int          CTRL_EN_BIT   = 0;
   localparam logic        CTRL_EN_RESET = 1'b1;
   localparam int          STAT_ILL_BIT  = 0;
   localparam int          STAT_BUSY_BIT = 1;
   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [7:0]  opcode;
      logic [3:0]  r1;
      logic [3:0]  x2;
      logic [15:0] addr_field;
   } hlsu_instr_type;
   typedef struct packed {
      logic        valid;
      logic        write;
      logic        byte_sel;
      logic [15:0] addr;
      logic [15:0] wdata;
   } hlsu_mem_req_type;
   typedef struct packed {
      logic        valid;
      logic [3:0]  index;
      logic [15:0] data;
   } hlsu_wb_type;
   typedef enum logic {ST_IDLE, ST_MEM} hlsu_state_type;
   typedef enum logic [2:0] {K_LH, K_STH, K_LB, K_STB, K_LM, K_AH} hlsu_kind_type;
endpackage : hlsu_pkg
`default_nettype wire

// File: test/hlsu_mem_model.sv
// file: core memory model answering the unit's memory requests
`default_nettype none
module hlsu_mem_model
   import hlsu_pkg::*;
(
   input  wire logic             i_clk_sys,
   input  wire hlsu_mem_req_type i_req,
   input  wire logic [1:0]       i_wait,
   output logic                  o_ack,
   output logic [15:0]           o_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0]  mem [0:255];
   logic [1:0]  cnt;
   logic [7:0]  a;
   logic [15:0] rd;
   initial begin
      o_ack = 1'b0;
      cnt = 2'h0;
      foreach (mem[k]) mem[k] = 8'h00;
   end
   assign a = i_req.addr[7:0];
   // big-endian halfword: bit 0 of the halfword is the msb of the lower byte
   assign rd = i_req.byte_sel ? {8'h00, mem[a]} : {mem[a], mem[a + 8'h01]};
   // outside an ack the data lines carry junk, so a late sample never matches
   assign o_rdata = o_ack ? rd : ~rd;
   always @(posedge i_clk_sys) begin
      if (o_ack) begin
         o_ack <= 1'b0;
         cnt <= 2'h0;
         if (i_req.write && i_req.byte_sel) begin
            mem[a] <= i_req.wdata[7:0];
         end else if (i_req.write) begin
            mem[a] <= i_req.wdata[15:8];
            mem[a + 8'h01] <= i_req.wdata[7:0];
         end
      end else if (i_req.valid === 1'b1) begin
         if (cnt >= i_wait) o_ack <= 1'b1;
         else cnt <= cnt + 2'h1;
      end
   end
endmodule : hlsu_mem_model
`default_nettype wire

// File: test/testbench.sv
// file: self-checking testbench of the halfword load/store unit
`default_nettype none
module testbench;
   import hlsu_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, nrst, ce, valid, ack, ready, busy, psel, penable, pwrite, pready, slverr, slv;
   hlsu_instr_type   instr;
   hlsu_mem_req_type req;
   hlsu_wb_type      wb;
   logic [15:0]      iaddr, rdata, pc;
   logic [31:0]      program_status_word, psw_seen, prdata, pwdata, rd_val;
   logic [11:0]      paddr;
   logic [1:0]       wt;
   int               bad_count, n_compared, cycles;
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   hlsu_core hlsu_core_i (.i_clk_sys(clk), .i_nrst(nrst), .i_ce(ce), .i_instr_valid(valid),
      .i_instr(instr), .i_instr_addr(iaddr), .o_instr_ready(ready), .o_mem_req(req),
      .i_mem_ack(ack), .i_mem_rdata(rdata), .o_wb(wb), .o_busy(busy), .o_psw(program_status_word),
      .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
      .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(slverr));
   hlsu_mem_model hlsu_mem_model_i (.i_clk_sys(clk), .i_req(req), .i_wait(wt), .o_ack(ack),
      .o_rdata(rdata));
   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic complete_run;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : complete_run
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
      n_compared++;
      if (seen !== exp) begin
         $display("unexpected %s expected %h seen %h", what, exp, seen);
         bad_count++;
      end
   endtask : chk
   // apb master: entered just after a rising edge, holds until pready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd_val = prdata;
      slv = slverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // one idle edge so a following call never re-raises psel in the same step
      @(posedge clk);
   endtask : apb
   task automatic gpr_w(input logic [3:0] n, input logic [15:0] v);
      apb(1'b1, ADDR_GPR_BASE + {6'h00, n, 2'b00}, {16'h0000, v});
   endtask : gpr_w
   task automatic gpr_chk(input string what, input logic [3:0] n, input logic [15:0] v);
      apb(1'b0, ADDR_GPR_BASE + {6'h00, n, 2'b00}, 32'h0000_0000);
      chk(what, {16'h0000, v}, rd_val);
   endtask : gpr_chk
   task automatic cc_chk(input logic [3:0] mask, input logic [3:0] v);
      chk("condition code", {28'h0, v}, {28'h0, psw_seen[PSW_CC_C:PSW_CC_L] & mask});
   endtask : cc_chk
   task automatic mem_chk(input logic [7:0] a, input logic [15:0] v);
      chk("memory", {16'h0, v}, {16'h0, hlsu_mem_model_i.mem[a], hlsu_mem_model_i.mem[a + 1]});
   endtask : mem_chk
   // offers one instruction, waits until it has finished, keeps the status word
   task automatic run(input logic [7:0] op, input logic [3:0] r1, x2, input logic [15:0] a);
      valid <= 1'b1;
      instr <= {op, r1, x2, a};
      iaddr <= pc;
      @(negedge clk);
      while (ready !== 1'b1) @(negedge clk);
      @(posedge clk);
      valid <= 1'b0;
      @(posedge clk);
      @(negedge clk);
      while (busy === 1'b1) @(negedge clk);
      @(posedge clk);
      @(negedge clk);
      psw_seen = program_status_word;
      chk("instruction address", {16'h0, pc}, {16'h0, program_status_word[15:0]});
      @(posedge clk);
      pc <= pc + 16'h0004;
   endtask : run
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_load_halfword;
      gpr_w(4'h3, 16'h8001);
      gpr_w(4'h2, 16'h0010);
      run(OP_LOAD_HALFWORD_REGREG, 4'h1, 4'h3, 16'h0);
      gpr_chk("load reg", 4'h1, 16'h8001);
      cc_chk(4'h3, 4'h1);
      run(OP_LOAD_HALFWORD_IMMEDIATE, 4'h4, 4'h2, 16'hFFF0);
      gpr_chk("load immediate", 4'h4, 16'h0000);
      cc_chk(4'h3, 4'h0);
      hlsu_mem_model_i.mem[8'h20] = 8'h12;
      hlsu_mem_model_i.mem[8'h21] = 8'h34;
      run(OP_LOAD_HALFWORD_MEMORY, 4'h5, 4'h2, 16'h0010);
      gpr_chk("load memory", 4'h5, 16'h1234);
      cc_chk(4'h3, 4'h2);
   endtask : t_load_halfword
   task automatic t_store;
      run(OP_STORE_HALFWORD_MEMORY, 4'h1, 4'h0, 16'h0030);
      mem_chk(8'h30, 16'h8001);
      cc_chk(4'hF, 4'h2);
      gpr_chk("store source", 4'h1, 16'h8001);
      gpr_w(4'h6, 16'hAB00);
      run(OP_STORE_BYTE_REGREG, 4'h1, 4'h6, 16'h0);
      gpr_chk("store byte reg", 4'h6, 16'hAB01);
      run(OP_STORE_BYTE_MEMORY, 4'h5, 4'h0, 16'h0041);
      mem_chk(8'h40, 16'h0034);
      cc_chk(4'hF, 4'h2);
   endtask : t_store
   task automatic t_load_byte;
      gpr_w(4'h7, 16'hFFFF);
      gpr_w(4'h8, 16'hFFFF);
      run(OP_LOAD_BYTE_REGREG, 4'h7, 4'h6, 16'h0);
      gpr_chk("load byte reg", 4'h7, 16'h0001);
      run(OP_LOAD_BYTE_MEMORY, 4'h8, 4'h2, 16'h0020);
      gpr_chk("load byte memory", 4'h8, 16'h0080);
      cc_chk(4'hF, 4'h2);
   endtask : t_load_byte
   task automatic t_load_multiple;
      for (int k = 0; k < 6; k++) hlsu_mem_model_i.mem[8'h50 + k] = 8'h11 * (k + 1);
      gpr_w(4'hC, 16'h5555);
      wt <= 2'h2;
      run(OP_LOAD_MULTIPLE, 4'hD, 4'h2, 16'h0040);
      wt <= 2'h0;
      gpr_chk("multiple first", 4'hD, 16'h1122);
      gpr_chk("multiple second", 4'hE, 16'h3344);
      gpr_chk("multiple last", 4'hF, 16'h5566);
      gpr_chk("multiple below", 4'hC, 16'h5555);
      cc_chk(4'hF, 4'h2);
   endtask : t_load_multiple
   task automatic t_add;
      gpr_w(4'h9, 16'h7FFF);
      gpr_w(4'hA, 16'h0001);
      run(OP_ADD_HALFWORD_REGREG, 4'h9, 4'hA, 16'h0);
      gpr_chk("add reg", 4'h9, 16'h8000);
      cc_chk(4'hF, 4'h5);
      hlsu_mem_model_i.mem[8'h60] = 8'hFF;
      hlsu_mem_model_i.mem[8'h61] = 8'hFF;
      run(OP_ADD_HALFWORD_MEMORY, 4'h9, 4'h2, 16'h0050);
      gpr_chk("add memory", 4'h9, 16'h7FFF);
      cc_chk(4'hF, 4'hE);
      run(OP_ADD_HALFWORD_IMMEDIATE, 4'h9, 4'hA, 16'h8000);
      gpr_chk("add immediate", 4'h9, 16'h0000);
      cc_chk(4'hF, 4'h8);
   endtask : t_add
   task automatic t_unmapped;
      apb(1'b0, 12'h020, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, slv});
      chk("unmapped data", 32'h0, rd_val);
   endtask : t_unmapped
   task automatic t_illegal;
      run(8'hFF, 4'h0, 4'h0, 16'h0);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk("illegal flag", 32'h1, rd_val);
      apb(1'b1, ADDR_STATUS, 32'h1);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk("illegal cleared", 32'h0, rd_val);
   endtask : t_illegal
   // ---------------------------------------------------------------
   // main sequence and hang guard
   // ---------------------------------------------------------------
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         bad_count++;
         complete_run();
      end
   end
   initial begin
      {nrst, valid, psel, penable, pwrite} = 5'h00;
      ce = 1'b1;
      instr = '0;
      {iaddr, pc, paddr, pwdata, wt} = '0;
      {bad_count, n_compared, cycles} = '0;
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      pc <= 16'h0100;
      @(posedge clk);
      t_load_halfword();
      t_store();
      t_load_byte();
      t_load_multiple();
      t_add();
      t_unmapped();
      t_illegal();
      complete_run();
   end
endmodule : testbench
`default_nettype wire
